// ==== pkg/boost_ctrl_cfg.svh ====
// offsets, field positions, reset values and fixed figures of the boost enable controller
`ifndef BOOST_CTRL_CFG_SVH
`define BOOST_CTRL_CFG_SVH

// apb register byte offsets
`define BK_ADDR_W          8
`define BK_OFF_CONTROL     8'h00
`define BK_OFF_STATUS      8'h04
`define BK_OFF_IRQ_STATUS  8'h08
`define BK_OFF_IRQ_MASK    8'h0c
`define BK_OFF_ZONE_A_PWM  8'h10
`define BK_OFF_ZONE_B_PWM  8'h14

// control register fields
`define BK_CTRL_W          8
`define BK_CTRL_RST        8'h00
`define BK_CTRL_STR1       0
`define BK_CTRL_STR2       1
`define BK_CTRL_STR3       2
`define BK_CTRL_S4_SEL     3
`define BK_CTRL_SCENE      4
`define BK_CTRL_S4_ADAPT   5
`define BK_CTRL_DUAL       6
`define BK_CTRL_PWM_EN     7

// interrupt status / mask fields
`define BK_IRQ_W           5
`define BK_IRQ_RST         5'h00
`define BK_IRQ_READY       0
`define BK_IRQ_UV          1
`define BK_IRQ_OV          2
`define BK_IRQ_INVALID     3
`define BK_IRQ_FAULT       4

// zone pwm register: duty in [15:0], period in [31:16]
`define BK_PWM_W           16
`define BK_ZONE_RST        32'h00ff_0080

// analog comparator inputs, index into the synchroniser vector
`define BK_AIN_W           5
`define BK_AIN_BELOW_UV    0
`define BK_AIN_ABOVE_UVH   1
`define BK_AIN_OVER_V      2
`define BK_AIN_BELOW_OVH   3
`define BK_AIN_STEADY      4

// fixed-reference output target, millivolts, shown in status [31:16]
`define BK_FIXED_TARGET_MV 16'h55f0

`endif

// ==== pkg/boost_ctrl_pkg.sv ====
// types shared by the boost enable controller
`include "boost_ctrl_cfg.svh"
package boost_ctrl_pkg;
  typedef enum logic [2:0] {
    ST_OFF      = 3'b000,
    ST_RAMP     = 3'b001,
    ST_READY    = 3'b010,
    ST_UV_FAULT = 3'b011,
    ST_OV_FAULT = 3'b100
  } boost_state_t;

  typedef struct packed {
    logic       boost_req;
    logic       adaptive;
    logic [3:0] node_sel;
    logic       invalid;
    logic       scene_only;
    logic       s4_camera;
    logic [3:0] zone_b;
    logic [3:0] sink_req;
    logic [3:0] pwm_mode;
  } decode_t;

  typedef struct packed {
    logic [`BK_CTRL_W-1:0] ctrl;
    logic [`BK_IRQ_W-1:0]  irq_stat;
    logic [`BK_IRQ_W-1:0]  irq_mask;
    logic [31:0]           zone_a_cfg;
    logic [31:0]           zone_b_cfg;
    logic [`BK_PWM_W-1:0]  cnt_a;
    logic [`BK_PWM_W-1:0]  cnt_b;
    boost_state_t          state;
    logic [`BK_AIN_W-1:0]  ain_meta;
    logic [`BK_AIN_W-1:0]  ain_sync;
    logic                  boost_en;
    logic                  ref_adaptive;
    logic                  ref_fixed;
    logic [3:0]            node_sel;
    logic                  uv_comp_en;
    logic                  fault;
    logic [3:0]            sink_on;
    logic                  irq;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
  } regs_t;
endpackage : boost_ctrl_pkg

// ==== core/boost_enable_ctrl.sv ====
// boost rail enable, reference select, zone routing and fault flag controller
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "boost_ctrl_cfg.svh"

module boost_enable_ctrl (
  input  wire logic                  i_clk_sys,           // system clock, 100 MHz
  input  wire logic                  i_reset,             // async reset, active high
  input  wire logic                  i_psel,              // apb select
  input  wire logic                  i_penable,           // apb access phase
  input  wire logic                  i_pwrite,            // apb direction, 1 = write
  input  wire logic [`BK_ADDR_W-1:0] i_paddr,             // apb byte address
  input  wire logic [31:0]           i_pwdata,            // apb write data
  output var  logic [31:0]           o_prdata,            // apb read data
  output var  logic                  o_pready,            // apb ready
  output var  logic                  o_pslverr,           // apb error, unmapped address
  input  wire logic                  i_out_below_uv,      // output below under-voltage level
  input  wire logic                  i_out_above_uv_hyst, // output above uv level plus hysteresis
  input  wire logic                  i_out_over_voltage,  // output above over-voltage level
  input  wire logic                  i_out_below_ov_hyst, // output below ov level minus hysteresis
  input  wire logic                  i_out_steady,        // output ramp has settled
  output var  logic                  o_boost_enable,      // run the boost converter
  output var  logic                  o_ref_adaptive,      // regulate from lowest selected node
  output var  logic                  o_ref_fixed,         // regulate to the fixed target
  output var  logic [3:0]            o_adapt_node_select, // sink nodes one..three, scene node
  output var  logic                  o_uv_comp_enable,    // under-voltage comparator power
  output var  logic                  o_boost_fault_flag,  // fault / not-ready flag
  output var  logic [3:0]            o_sink_enable,       // current sink drive, strings 1..4
  output var  logic                  o_irq                // level interrupt
);

  boost_ctrl_pkg::regs_t   q;         // every flip-flop of the block
  boost_ctrl_pkg::regs_t   d;         // next value of every flip-flop
  boost_ctrl_pkg::decode_t dec;       // decode of the live control register
  boost_ctrl_pkg::decode_t dec_wr;    // decode of a control value being written

  // turn the enable bits into load, reference and zone decisions.
  // used both for the live register and to flag a bad write.
  function automatic boost_ctrl_pkg::decode_t decode_ctrl(
    input logic [`BK_CTRL_W-1:0] c
  );
    boost_ctrl_pkg::decode_t r;
    logic                    any13;
    logic                    s4_bl;
    logic                    dual;
    r        = '0;
    any13    = c[`BK_CTRL_STR1] | c[`BK_CTRL_STR2] | c[`BK_CTRL_STR3];
    dual     = c[`BK_CTRL_DUAL];
    // string four select counts only with the scene enable
    s4_bl    = c[`BK_CTRL_SCENE] & c[`BK_CTRL_S4_SEL];
    // pwm sinks together with backlight strings one..three is illegal
    r.invalid = c[`BK_CTRL_PWM_EN] & any13;
    if (r.invalid) begin
      // keep everything dark rather than guess a drive
      r = '0;
      r.invalid = 1'b1;
    end else begin
      // the rail only runs for a backlight string or the scene string
      r.boost_req = any13 | c[`BK_CTRL_SCENE];
      // adaptive whenever a backlight load or the scene string with adapt select is active
      r.adaptive  = any13 | s4_bl | (c[`BK_CTRL_SCENE] & c[`BK_CTRL_S4_ADAPT]);
      r.node_sel[0] = c[`BK_CTRL_STR1];
      r.node_sel[1] = c[`BK_CTRL_STR2];
      r.node_sel[2] = c[`BK_CTRL_STR3];
      // camera use leaves the scene node out unless adapt select is set
      r.node_sel[3] = s4_bl | (c[`BK_CTRL_SCENE] & c[`BK_CTRL_S4_ADAPT]);
      r.scene_only  = c[`BK_CTRL_SCENE] & ~any13;
      r.s4_camera   = c[`BK_CTRL_SCENE] & ~c[`BK_CTRL_S4_SEL];
      // strings one and two always sit in zone a; three moves with dual
      r.zone_b[2]   = dual;
      // string four backlight: zone a normally, zone b in dual mode
      r.zone_b[3]   = dual;
      // string requests; the open-drain mode reuses sinks one..three
      r.sink_req[0] = c[`BK_CTRL_STR1] | c[`BK_CTRL_PWM_EN];
      r.sink_req[1] = c[`BK_CTRL_STR2] | c[`BK_CTRL_PWM_EN];
      r.sink_req[2] = c[`BK_CTRL_STR3] | c[`BK_CTRL_PWM_EN];
      r.sink_req[3] = c[`BK_CTRL_SCENE];
      r.pwm_mode    = {1'b0, {3{c[`BK_CTRL_PWM_EN]}}};
    end
    return r;
  endfunction : decode_ctrl

  // free-running pwm counter step, wraps after the programmed period
  function automatic logic [`BK_PWM_W-1:0] pwm_step(
    input logic [`BK_PWM_W-1:0] cnt,
    input logic [`BK_PWM_W-1:0] period
  );
    return (cnt >= period) ? '0 : cnt + `BK_PWM_W'(1);
  endfunction : pwm_step

  // all next-state logic in one place
  always_comb begin : next_state
    logic                 acc_first;   // first access cycle, answer is prepared
    logic                 acc_done;    // completing edge, writes land here
    logic                 wr;          // completed write
    logic                 mapped;      // address hits a register
    logic [31:0]          rdata;       // read mux
    logic [`BK_IRQ_W-1:0] ev;          // events raised this cycle
    logic [`BK_IRQ_W-1:0] clr;         // write-one-to-clear mask
    logic                 pwm_a;       // zone a pwm level
    logic                 pwm_b;       // zone b pwm level
    logic                 run_ok;      // rail settled enough to light leds
    d         = q;
    pwm_a     = 1'b0;
    pwm_b     = 1'b0;
    run_ok    = 1'b0;
    ev        = '0;
    clr       = '0;
    rdata     = '0;
    mapped    = 1'b1;
    acc_first = i_psel & i_penable & ~q.pready;
    acc_done  = i_psel & i_penable & q.pready;
    wr        = acc_done & i_pwrite & ~q.pslverr;
    dec       = decode_ctrl(q.ctrl);
    dec_wr    = decode_ctrl(i_pwdata[`BK_CTRL_W-1:0]);

    // two-stage synchroniser for the analog comparator levels
    d.ain_meta = {i_out_steady, i_out_below_ov_hyst, i_out_over_voltage,
                  i_out_above_uv_hyst, i_out_below_uv};
    d.ain_sync = q.ain_meta;

    // apb: one wait state, so the answer is registered like every output
    d.pready = acc_first;
    if (acc_first) begin
      unique case (i_paddr)
        `BK_OFF_CONTROL:    rdata = {24'h00_0000, q.ctrl};
        // status: target mV, zone b members, node select, flags, state
        `BK_OFF_STATUS:     rdata = {`BK_FIXED_TARGET_MV, dec.zone_b, q.node_sel,
                                     q.uv_comp_en, q.fault, q.ref_fixed,
                                     q.ref_adaptive, q.boost_en, q.state};
        `BK_OFF_IRQ_STATUS: rdata = {27'h000_0000, q.irq_stat};
        `BK_OFF_IRQ_MASK:   rdata = {27'h000_0000, q.irq_mask};
        `BK_OFF_ZONE_A_PWM: rdata = q.zone_a_cfg;
        `BK_OFF_ZONE_B_PWM: rdata = q.zone_b_cfg;
        default:            mapped = 1'b0;
      endcase
      d.prdata  = rdata;
      d.pslverr = ~mapped;
    end else if (acc_done) begin
      // drop the answer once taken so a stale error never lingers
      d.prdata  = '0;
      d.pslverr = 1'b0;
    end

    // register writes at the completing edge; status is read-only
    if (wr) begin
      unique case (i_paddr)
        `BK_OFF_CONTROL: begin
          d.ctrl = i_pwdata[`BK_CTRL_W-1:0];
          // a rejected combination is reported, the value still stored
          ev[`BK_IRQ_INVALID] = dec_wr.invalid;
        end
        `BK_OFF_IRQ_STATUS: clr = i_pwdata[`BK_IRQ_W-1:0];
        `BK_OFF_IRQ_MASK:   d.irq_mask = i_pwdata[`BK_IRQ_W-1:0];
        `BK_OFF_ZONE_A_PWM: d.zone_a_cfg = i_pwdata;
        `BK_OFF_ZONE_B_PWM: d.zone_b_cfg = i_pwdata;
        default:            d.ctrl = q.ctrl;
      endcase
    end

    // boost sequencer; removing every load drops straight to off
    unique case (q.state)
      boost_ctrl_pkg::ST_OFF: begin
        if (dec.boost_req) begin
          d.state = boost_ctrl_pkg::ST_RAMP;
        end
      end
      boost_ctrl_pkg::ST_RAMP: begin
        if (q.ain_sync[`BK_AIN_OVER_V]) begin
          d.state = boost_ctrl_pkg::ST_OV_FAULT;
        end else if (q.ain_sync[`BK_AIN_STEADY]) begin
          d.state = boost_ctrl_pkg::ST_READY;
          ev[`BK_IRQ_READY] = 1'b1;
        end
      end
      boost_ctrl_pkg::ST_READY: begin
        if (q.ain_sync[`BK_AIN_OVER_V]) begin
          d.state = boost_ctrl_pkg::ST_OV_FAULT;
        end else if (q.uv_comp_en & q.ain_sync[`BK_AIN_BELOW_UV]) begin
          // only a powered comparator can report an under-voltage
          d.state = boost_ctrl_pkg::ST_UV_FAULT;
        end
      end
      boost_ctrl_pkg::ST_UV_FAULT: begin
        if (q.ain_sync[`BK_AIN_OVER_V]) begin
          d.state = boost_ctrl_pkg::ST_OV_FAULT;
        end else if (q.ain_sync[`BK_AIN_ABOVE_UVH]) begin
          d.state = boost_ctrl_pkg::ST_READY;
        end
      end
      boost_ctrl_pkg::ST_OV_FAULT: begin
        // resume only once below the lower hysteresis point
        if (q.ain_sync[`BK_AIN_BELOW_OVH]) begin
          d.state = boost_ctrl_pkg::ST_READY;
        end
      end
      default: d.state = boost_ctrl_pkg::ST_OFF;
    endcase
    if (!dec.boost_req) begin
      d.state = boost_ctrl_pkg::ST_OFF;
    end

    // events on entry to the fault states
    ev[`BK_IRQ_UV] = (d.state == boost_ctrl_pkg::ST_UV_FAULT) &
                     (q.state != boost_ctrl_pkg::ST_UV_FAULT);
    ev[`BK_IRQ_OV] = (d.state == boost_ctrl_pkg::ST_OV_FAULT) &
                     (q.state != boost_ctrl_pkg::ST_OV_FAULT);

    // flag high from turn-on until ready, and in either fault state
    d.fault = (d.state == boost_ctrl_pkg::ST_RAMP) |
              (d.state == boost_ctrl_pkg::ST_UV_FAULT) |
              (d.state == boost_ctrl_pkg::ST_OV_FAULT);
    ev[`BK_IRQ_FAULT] = d.fault & ~q.fault;

    // over-voltage stops switching; the rail is otherwise on while loaded
    d.boost_en = (d.state == boost_ctrl_pkg::ST_RAMP) |
                 (d.state == boost_ctrl_pkg::ST_READY) |
                 (d.state == boost_ctrl_pkg::ST_UV_FAULT);

    // comparator: always during ramp, afterwards only for scene-only load,
    // since a backlight-tracked output moves with led current
    d.uv_comp_en = (d.state == boost_ctrl_pkg::ST_RAMP) |
                   (((d.state == boost_ctrl_pkg::ST_READY) |
                     (d.state == boost_ctrl_pkg::ST_UV_FAULT)) &
                    dec.scene_only);

    // reference choice follows the live enables while the rail runs
    d.ref_adaptive = d.boost_en & dec.adaptive;
    d.ref_fixed    = d.boost_en & ~dec.adaptive;
    d.node_sel     = d.boost_en ? dec.node_sel : 4'h0;

    // two independent pwm generators, one per zone, same rail
    d.cnt_a = pwm_step(q.cnt_a, q.zone_a_cfg[31:16]);
    d.cnt_b = pwm_step(q.cnt_b, q.zone_b_cfg[31:16]);
    pwm_a   = q.cnt_a < q.zone_a_cfg[`BK_PWM_W-1:0];
    pwm_b   = q.cnt_b < q.zone_b_cfg[`BK_PWM_W-1:0];

    // leds powered by the rail wait for ready and go dark on over-voltage
    run_ok    = (q.state == boost_ctrl_pkg::ST_READY) |
                (q.state == boost_ctrl_pkg::ST_UV_FAULT);
    for (int i = 0; i < 4; i++) begin
      if (!dec.sink_req[i]) begin
        d.sink_on[i] = 1'b0;
      end else if (dec.pwm_mode[i]) begin
        // open-drain pwm has its own pull-up and needs no rail
        d.sink_on[i] = dec.zone_b[i] ? pwm_b : pwm_a;
      end else if (i == 3 && dec.s4_camera) begin
        // camera lighting is a steady load, not part of either zone
        d.sink_on[i] = run_ok;
      end else begin
        d.sink_on[i] = run_ok & (dec.zone_b[i] ? pwm_b : pwm_a);
      end
    end
    d.sink_on = dec.invalid ? 4'h0 : d.sink_on;

    // sticky events: a set in the clearing cycle wins
    d.irq_stat = (q.irq_stat & ~clr) | ev;
    d.irq      = |(d.irq_stat & d.irq_mask);
  end : next_state

  // single register stage for the whole block
  always_ff @(posedge i_clk_sys or posedge i_reset) begin : state_regs
    if (i_reset) begin
      q            <= '0;
      q.ctrl       <= `BK_CTRL_RST;
      q.irq_stat   <= `BK_IRQ_RST;
      q.irq_mask   <= `BK_IRQ_RST;
      q.zone_a_cfg <= `BK_ZONE_RST;
      q.zone_b_cfg <= `BK_ZONE_RST;
      q.state      <= boost_ctrl_pkg::ST_OFF;
    end else begin
      q <= d;
    end
  end : state_regs

  // outputs straight from the register stage
  assign o_prdata            = q.prdata;
  assign o_pready            = q.pready;
  assign o_pslverr           = q.pslverr;
  assign o_boost_enable      = q.boost_en;
  assign o_ref_adaptive      = q.ref_adaptive;
  assign o_ref_fixed         = q.ref_fixed;
  assign o_adapt_node_select = q.node_sel;
  assign o_uv_comp_enable    = q.uv_comp_en;
  assign o_boost_fault_flag  = q.fault;
  assign o_sink_enable       = q.sink_on;
  assign o_irq               = q.irq;

endmodule : boost_enable_ctrl
`default_nettype wire

// ==== verification/boost_stage_model.sv ====
// behavioural boost stage and output comparators facing the enable controller
`timescale 1ns/1ps
`default_nettype none

module boost_stage_model (
  input  wire logic i_clk_sys,       // system clock
  input  wire logic i_boost_enable,  // controller runs the converter
  input  wire logic i_uv_force,      // bench pulls the output under the uv level
  input  wire logic i_ov_force,      // bench pushes the output over the ov level
  output var  logic o_below_uv,      // output under the uv level
  output var  logic o_above_uv_hyst, // output above uv level plus hysteresis
  output var  logic o_over_voltage,  // output above the ov level
  output var  logic o_below_ov_hyst, // output under ov level minus hysteresis
  output var  logic o_steady         // ramp has settled
);
  logic [3:0] ramp_q    = 4'h0; // output rise in cycles; charge is kept through an ov stop
  logic       ov_hold_q = 1'b0; // switching stopped by an ov event, not by a load removal

  // the controller resumes a few cycles after the ov clears; keep the charge in that gap
  always_ff @(posedge i_clk_sys) begin
    ov_hold_q <= i_ov_force || (ov_hold_q && !i_boost_enable);
    if (i_boost_enable && ramp_q != 4'hf) begin
      ramp_q <= ramp_q + 4'h1;
    end else if (!i_boost_enable && !i_ov_force && !ov_hold_q) begin
      ramp_q <= 4'h0;
    end
  end

  // a collapsed output reads as under-voltage, never as good
  always_comb begin
    o_steady        = (ramp_q == 4'hf);
    o_below_uv      = !o_steady || i_uv_force;
    o_above_uv_hyst = o_steady && !i_uv_force;
    o_over_voltage  = i_ov_force;
    o_below_ov_hyst = !i_ov_force;
  end
endmodule : boost_stage_model
`default_nettype wire

// ==== verification/boost_enable_ctrl_assertions.sv ====
// assertion checker for the boost enable controller, bound to its ports
`timescale 1ns/1ps
`default_nettype none
`include "boost_ctrl_cfg.svh"

module boost_enable_ctrl_checker (
  input wire logic                  i_clk_sys,
  input wire logic                  i_reset,
  input wire logic                  i_psel,
  input wire logic                  i_penable,
  input wire logic                  i_pwrite,
  input wire logic [`BK_ADDR_W-1:0] i_paddr,
  input wire logic [31:0]           i_pwdata,
  input wire logic                  o_pready,
  input wire logic                  i_out_below_uv,
  input wire logic                  i_out_above_uv_hyst,
  input wire logic                  i_out_over_voltage,
  input wire logic                  i_out_steady,
  input wire logic                  o_boost_enable,
  input wire logic                  o_ref_adaptive,
  input wire logic                  o_ref_fixed,
  input wire logic [3:0]            o_adapt_node_select,
  input wire logic                  o_uv_comp_enable,
  input wire logic                  o_boost_fault_flag,
  input wire logic [3:0]            o_sink_enable
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  logic [`BK_CTRL_W-1:0] ctrl_q;   // shadow of the control register
  logic [2:0]            age_q;    // cycles since the last control write, saturating
  logic                  ctl_wr;   // control write lands this edge
  logic                  strs;     // any of strings one..three enabled
  logic                  settled;  // outputs have had time to follow the control word

  assign ctl_wr  = i_psel && i_penable && i_pwrite && o_pready && i_paddr == `BK_OFF_CONTROL;
  assign strs    = |ctrl_q[2:0];
  assign settled = (age_q == 3'h7);

  // track the control word; decode checks wait until the outputs could have moved
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      ctrl_q <= '0;
      age_q  <= '0;
    end else if (ctl_wr) begin
      ctrl_q <= i_pwdata[`BK_CTRL_W-1:0];
      age_q  <= '0;
    end else if (!settled) begin
      age_q  <= age_q + 3'h1;
    end
  end

  sequence s_turn_on;
    $rose(o_boost_enable) && !$past(o_boost_fault_flag);
  endsequence
  sequence s_uv_low;
    (o_uv_comp_enable && o_boost_enable && !o_boost_fault_flag && i_out_below_uv) [*3];
  endsequence
  sequence s_out_good;
    (o_boost_enable && o_boost_fault_flag && i_out_steady && i_out_above_uv_hyst
      && !i_out_below_uv && !i_out_over_voltage) [*2];
  endsequence

  chk_turn_on_flag: assert property (s_turn_on |-> o_boost_fault_flag && o_uv_comp_enable)
    else $error("turn-on without fault flag and comparator");
  chk_uv_sets_flag: assert property (s_uv_low |-> ##[0:5] o_boost_fault_flag)
    else $error("under-voltage did not raise the fault flag");
  chk_flag_clears: assert property (s_out_good |-> ##[0:6] !o_boost_fault_flag)
    else $error("fault flag stuck with a good output");
  chk_ov_stops: assert property (o_boost_enable && i_out_over_voltage
    |-> ##[1:6] (!o_boost_enable && o_boost_fault_flag))
    else $error("over-voltage did not stop the boost");
  chk_no_load_off: assert property (settled && !strs && !ctrl_q[`BK_CTRL_SCENE]
    |-> !o_boost_enable && !o_uv_comp_enable && o_adapt_node_select == 4'h0)
    else $error("boost running without a load");
  chk_invalid_dark: assert property (settled && ctrl_q[`BK_CTRL_PWM_EN] && strs
    |-> !o_boost_enable && o_sink_enable == 4'h0)
    else $error("invalid enables left drive on");
  chk_fixed_ref: assert property (settled && o_boost_enable && !strs
    && ctrl_q[`BK_CTRL_SCENE] && !ctrl_q[`BK_CTRL_S4_ADAPT] && !ctrl_q[`BK_CTRL_S4_SEL]
    |-> o_ref_fixed && !o_ref_adaptive)
    else $error("scene only should use the fixed reference");
  chk_adapt_nodes: assert property (settled && o_boost_enable && (strs ||
    (ctrl_q[`BK_CTRL_SCENE] && (ctrl_q[`BK_CTRL_S4_SEL] || ctrl_q[`BK_CTRL_S4_ADAPT])))
    |-> o_ref_adaptive && !o_ref_fixed && o_adapt_node_select == {ctrl_q[`BK_CTRL_SCENE]
    && (ctrl_q[`BK_CTRL_S4_SEL] || ctrl_q[`BK_CTRL_S4_ADAPT]), ctrl_q[2:0]})
    else $error("adaptive reference nodes wrong");
  chk_uv_off_bklt: assert property (settled && strs && o_boost_enable
    && !o_boost_fault_flag |-> !o_uv_comp_enable)
    else $error("comparator on after ready with backlight");
  chk_uv_on_scene: assert property (settled && ctrl_q[`BK_CTRL_SCENE] && !strs
    && o_boost_enable |-> o_uv_comp_enable)
    else $error("comparator off with scene only");
endmodule : boost_enable_ctrl_checker

bind boost_enable_ctrl boost_enable_ctrl_checker boost_enable_ctrl_checker_inst (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
  .i_out_below_uv(i_out_below_uv), .i_out_above_uv_hyst(i_out_above_uv_hyst),
  .i_out_over_voltage(i_out_over_voltage), .i_out_steady(i_out_steady),
  .o_boost_enable(o_boost_enable), .o_ref_adaptive(o_ref_adaptive),
  .o_ref_fixed(o_ref_fixed), .o_adapt_node_select(o_adapt_node_select),
  .o_uv_comp_enable(o_uv_comp_enable), .o_boost_fault_flag(o_boost_fault_flag),
  .o_sink_enable(o_sink_enable));
`default_nettype wire

// ==== verification/boost_enable_ctrl_tb.sv ====
// self-checking bench for the boost enable controller
`timescale 1ns/1ps
`default_nettype none
`include "boost_ctrl_cfg.svh"
`define TB_CHK(a, e) begin comparisons++; if ((a) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

module boost_enable_ctrl_tb;
  logic        i_clk_sys, i_reset, i_psel, i_penable, i_pwrite, uv_force, ov_force, steady;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic        o_pready, o_pslverr, err, o_irq, o_boost_enable, o_ref_adaptive, o_ref_fixed;
  logic        o_uv_comp_enable, o_boost_fault_flag, below_uv, above_uvh, over_v, below_ovh;
  logic [3:0]  o_adapt_node_select, o_sink_enable;
  wire [11:0]  link_st = {o_boost_enable, o_ref_adaptive, o_ref_fixed, o_uv_comp_enable,
                          o_adapt_node_select, o_sink_enable}; // analog-side outputs
  int          error_cnt = 0;
  int          comparisons = 0;
  // control word, then {boost, adaptive, fixed, uv comp, nodes, sinks}; zone a dark, b lit
  logic [19:0] cfg_tab [11] = '{20'h00_000, 20'h08_000, 20'h30_d88, 20'h18_d80, 20'h58_d88,
    20'h01_c10, 20'h45_c54, 20'h17_c78, 20'hc0_004, 20'h81_000, 20'h90_b08};

  boost_enable_ctrl boost_enable_ctrl_inst (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_out_below_uv(below_uv),
    .i_out_above_uv_hyst(above_uvh), .i_out_over_voltage(over_v),
    .i_out_below_ov_hyst(below_ovh), .i_out_steady(steady), .o_boost_enable(o_boost_enable),
    .o_ref_adaptive(o_ref_adaptive), .o_ref_fixed(o_ref_fixed),
    .o_adapt_node_select(o_adapt_node_select), .o_uv_comp_enable(o_uv_comp_enable),
    .o_boost_fault_flag(o_boost_fault_flag), .o_sink_enable(o_sink_enable), .o_irq(o_irq));

  boost_stage_model boost_stage_model_inst (
    .i_clk_sys(i_clk_sys), .i_boost_enable(o_boost_enable), .i_uv_force(uv_force),
    .i_ov_force(ov_force), .o_below_uv(below_uv), .o_above_uv_hyst(above_uvh),
    .o_over_voltage(over_v), .o_below_ov_hyst(below_ovh), .o_steady(steady));

  // free-running 100 MHz clock
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  // one apb transfer: setup, then access held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    i_psel   <= 1'b1;
    i_pwrite <= wr;
    i_paddr  <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (o_pready !== 1'b1) error_cnt++;
    rd = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `TB_CHK(rd, e)
  endtask : rdchk

  task automatic give_verdict();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // hang guard, well beyond the seven hundred or so cycles the tests need
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    error_cnt++;
    give_verdict();
  end

  initial begin
    {i_reset, i_psel, i_penable, i_pwrite, uv_force, ov_force} = 6'b100000;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    repeat (16) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    // reset values and idle outputs
    `TB_CHK({o_boost_enable, o_boost_fault_flag, o_sink_enable, o_irq}, 7'h00)
    rdchk(`BK_OFF_CONTROL, 32'h0);
    rdchk(`BK_OFF_STATUS, 32'h55f0_0000);
    rdchk(`BK_OFF_IRQ_MASK, 32'h0);
    rdchk(`BK_OFF_ZONE_A_PWM, `BK_ZONE_RST);
    $display("test reset done");
    // scene only: ramp, ready, under-voltage and over-voltage episodes
    apb(1'b1, `BK_OFF_ZONE_A_PWM, 32'h00ff_0000);
    apb(1'b1, `BK_OFF_ZONE_B_PWM, 32'h00ff_ffff);
    apb(1'b1, `BK_OFF_CONTROL, 32'h10);
    repeat (3) @(posedge i_clk_sys);
    `TB_CHK({o_boost_fault_flag, link_st}, 13'h1b00)
    repeat (40) @(posedge i_clk_sys);
    `TB_CHK({o_boost_fault_flag, link_st}, 13'h0b08)
    uv_force <= 1'b1;
    repeat (10) @(posedge i_clk_sys);
    `TB_CHK(o_boost_fault_flag, 1'b1)
    uv_force <= 1'b0;
    repeat (10) @(posedge i_clk_sys);
    `TB_CHK(o_boost_fault_flag, 1'b0)
    ov_force <= 1'b1;
    repeat (10) @(posedge i_clk_sys);
    `TB_CHK({o_boost_enable, o_boost_fault_flag}, 2'b01)
    ov_force <= 1'b0;
    repeat (40) @(posedge i_clk_sys);
    `TB_CHK({o_boost_enable, o_boost_fault_flag}, 2'b10)
    $display("test scene faults done");
    // every enable combination of interest, each settled before checking
    foreach (cfg_tab[k]) begin
      apb(1'b1, `BK_OFF_CONTROL, {24'h0, cfg_tab[k][19:12]});
      repeat (40) @(posedge i_clk_sys);
      `TB_CHK(link_st, cfg_tab[k][11:0])
    end
    $display("test enable table done");
    // interrupts, read-only status and an unmapped address
    `TB_CHK(o_irq, 1'b0)
    rdchk(`BK_OFF_IRQ_STATUS, 32'h0000_001f);
    apb(1'b1, `BK_OFF_IRQ_MASK, 32'h0000_001f);
    repeat (2) @(posedge i_clk_sys);
    `TB_CHK(o_irq, 1'b1)
    apb(1'b1, `BK_OFF_IRQ_STATUS, 32'h0000_001f);
    repeat (2) @(posedge i_clk_sys);
    `TB_CHK(o_irq, 1'b0)
    rdchk(`BK_OFF_IRQ_STATUS, 32'h0);
    apb(1'b1, `BK_OFF_STATUS, 32'hffff_ffff);
    rdchk(`BK_OFF_STATUS, 32'h55f0_00aa);
    apb(1'b0, 8'h20, 32'h0);
    `TB_CHK(err, 1'b1)
    $display("test registers done");
    give_verdict();
  end
endmodule : boost_enable_ctrl_tb
`default_nettype wire
